// file: rtl/oob_cfg.svh
`ifndef OOB_CFG_SVH
`define OOB_CFG_SVH

// =====================================================================
// Clock and sequence counts.
`define OOB_CLK_MHZ 125
`define OOB_REPEATS 6
`define OOB_DETECT_PAIRS 4
`define OOB_PS_SIGNALS 5
`define OOB_CNT_W 16

// =====================================================================
// Times in ns; plain defaults, the real values are set per system.
`define OOB_BURST_NS 106
`define OOB_INIT_IDLE_NS 320
`define OOB_WAKE_IDLE_NS 106
`define OOB_SAS_IDLE_NS 960
`define OOB_INIT_NEG_NS 480
`define OOB_WAKE_NEG_NS 160
`define OOB_SAS_NEG_NS 1440
`define OOB_PS_A_NS 20000
`define OOB_PS_B_NS 40000
`define OOB_BURST_PRIMS_G1 16

// Every time rounds down to whole cycles.
`define OOB_CYC(ns) ((ns) * `OOB_CLK_MHZ / 1000)

`endif

// file: rtl/oob_phy.sv
`timescale 1ns/100ps
`include "oob_cfg.svh"

// Notes on behaviour
// - Send six rounds of idle time then burst time for each signal.
// - After the sixth burst hold idle for the negation time, then complete.
// - Bursts are filled with ALIGN (0) primitives; idle gaps carry no transitions.
// - Bursts go at the first-generation rate, else lowest supported, never faster.
// - Second-generation bursts carry twice the first-generation primitive count.
// - The received signal is told apart only by the idle gap length.
// - Report a signal after four consecutive idle/burst pairs of its timing.
// - More than four pairs of the same signal is not an error.
// - No repeat detection until its negation time or a different signal.
// - Bursts at any rate up to the highest supported one are detected.
// - With SATA attach enabled, D24.3 bursts also count as valid bursts.
// - Initialisation and reset signals are one and the same signal.
// - The phy announces itself as SAS by sending the SAS-specific signal.
// - Port selection is five initialisation signals spaced by interval a or b.
// - Transmit timing runs from a fixed clock without spread-spectrum modulation.
// - SATA-capable receive accepts spread-spectrum streams.
// - Data from a SATA device is retimed onto the internal clock.
// - The recovered receive clock never clocks the transmit path.
// - Transmit must work when the partner tracks our transmit clock.
module oob_phy #(
  parameter int BURST_CYC = `OOB_CYC(`OOB_BURST_NS),
  parameter int INIT_IDLE_CYC = `OOB_CYC(`OOB_INIT_IDLE_NS),
  parameter int WAKE_IDLE_CYC = `OOB_CYC(`OOB_WAKE_IDLE_NS),
  parameter int SAS_IDLE_CYC = `OOB_CYC(`OOB_SAS_IDLE_NS),
  parameter int INIT_NEG_CYC = `OOB_CYC(`OOB_INIT_NEG_NS),
  parameter int WAKE_NEG_CYC = `OOB_CYC(`OOB_WAKE_NEG_NS),
  parameter int SAS_NEG_CYC = `OOB_CYC(`OOB_SAS_NEG_NS),
  parameter int PS_A_CYC = `OOB_CYC(`OOB_PS_A_NS),
  parameter int PS_B_CYC = `OOB_CYC(`OOB_PS_B_NS),
  parameter int BURST_PRIMS_G1 = `OOB_BURST_PRIMS_G1
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic nrst,
  // Transmit requests.
  input wire logic tx_req,
  input wire oob_pkg::oob_sig_t tx_kind,
  input wire logic ps_req,
  input wire logic [3:0] ps_pick_b,
  // Rate capability and attach mode.
  input wire logic gen1_capable,
  input wire logic [1:0] lowest_rate,
  input wire logic sata_attach,
  // Receive side, from the line detector and decoder.
  input wire logic rx_envelope,
  input wire oob_pkg::oob_pat_t rx_pattern,
  // Transmit side outputs.
  output logic tx_burst,
  output logic tx_send_align,
  output logic [1:0] tx_rate,
  output logic [7:0] tx_burst_prims,
  output logic tx_busy,
  output logic tx_done,
  output logic ps_done,
  // Receive side outputs.
  output oob_pkg::oob_det_t rx_detect
);
  localparam int CW = `OOB_CNT_W;
  typedef enum logic [2:0] {
    t_off,
    t_gap,
    t_burst,
    t_neg,
    t_pswait
  } tx_state_t;
  // =====================================================================
  // Reset release.
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'h1};
  end
  assign rst_n = rst_sync_q[1];

  // =====================================================================
  // Timing lookups.
  function automatic logic [CW-1:0] idle_of(oob_pkg::oob_sig_t k);
    case (k)
      oob_pkg::sig_wake: idle_of = CW'(WAKE_IDLE_CYC);
      oob_pkg::sig_sas: idle_of = CW'(SAS_IDLE_CYC);
      default: idle_of = CW'(INIT_IDLE_CYC);
    endcase
  endfunction
  function automatic logic [CW-1:0] neg_of(oob_pkg::oob_sig_t k);
    case (k)
      oob_pkg::sig_wake: neg_of = CW'(WAKE_NEG_CYC);
      oob_pkg::sig_sas: neg_of = CW'(SAS_NEG_CYC);
      default: neg_of = CW'(INIT_NEG_CYC);
    endcase
  endfunction
  // =====================================================================
  // Transmit sequencer; timed purely from mclk, a fixed local clock.
  tx_state_t tst_q;
  oob_pkg::oob_sig_t tkind_q;
  logic [CW-1:0] tcnt_q;
  logic [2:0] reps_q;
  logic [2:0] ps_left_q;
  logic [3:0] ps_pick_q;
  logic [CW-1:0] ps_elapsed_q;
  logic [CW-1:0] ps_gap;
  assign ps_gap = ps_pick_q[0] ? CW'(PS_B_CYC) : CW'(PS_A_CYC);
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tst_q <= t_off;
      tkind_q <= oob_pkg::sig_init;
      tcnt_q <= '0;
      reps_q <= 3'h0;
      ps_left_q <= 3'h0;
      ps_pick_q <= 4'h0;
    end
    else
    begin
      case (tst_q)
        t_off:
        begin
          if (ps_req)
          begin
            tst_q <= t_gap;
            tkind_q <= oob_pkg::sig_init;
            ps_left_q <= 3'(`OOB_PS_SIGNALS - 1);
            ps_pick_q <= ps_pick_b;
            tcnt_q <= '0;
            reps_q <= 3'h0;
          end
          else if (tx_req && tx_kind != oob_pkg::sig_none)
          begin
            tst_q <= t_gap;
            tkind_q <= tx_kind;
            tcnt_q <= '0;
            reps_q <= 3'h0;
          end
        end
        t_gap:
        begin
          if (tcnt_q >= idle_of(tkind_q) - CW'(1))
          begin
            tst_q <= t_burst;
            tcnt_q <= '0;
          end
          else
            tcnt_q <= tcnt_q + CW'(1);
        end
        t_burst:
        begin
          if (tcnt_q >= CW'(BURST_CYC - 1))
          begin
            tcnt_q <= '0;
            reps_q <= reps_q + 3'h1;
            if (reps_q == 3'(`OOB_REPEATS - 1))
              tst_q <= t_neg;
            else
              tst_q <= t_gap;
          end
          else
            tcnt_q <= tcnt_q + CW'(1);
        end
        t_neg:
        begin
          if (tcnt_q >= neg_of(tkind_q) - CW'(1))
          begin
            tcnt_q <= '0;
            tst_q <= (ps_left_q != 3'h0) ? t_pswait : t_off;
          end
          else
            tcnt_q <= tcnt_q + CW'(1);
        end
        t_pswait:
        begin
          if (ps_elapsed_q >= ps_gap - CW'(1))
          begin
            tst_q <= t_gap;
            reps_q <= 3'h0;
            ps_left_q <= ps_left_q - 3'h1;
            ps_pick_q <= {1'h0, ps_pick_q[3:1]};
          end
        end
        default: tst_q <= t_off;
      endcase
    end
  end

  // Selection interval runs from the start of each signal's first burst.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ps_elapsed_q <= '0;
    else if (tst_q == t_gap && reps_q == 3'h0 && tcnt_q >= idle_of(tkind_q) - CW'(1))
      ps_elapsed_q <= '0;
    else if (ps_elapsed_q != {CW{1'h1}})
      ps_elapsed_q <= ps_elapsed_q + CW'(1);
  end

  // Transmit outputs.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_burst <= 1'h0;
      tx_send_align <= 1'h0;
      tx_rate <= 2'h0;
      tx_burst_prims <= 8'h0;
      tx_busy <= 1'h0;
      tx_done <= 1'h0;
      ps_done <= 1'h0;
    end
    else
    begin
      tx_burst <= (tst_q == t_burst);
      tx_send_align <= (tst_q == t_burst);
      tx_rate <= gen1_capable ? 2'h0 : lowest_rate;
      tx_burst_prims <= (gen1_capable || lowest_rate == 2'h0) ?
        8'(BURST_PRIMS_G1) : 8'(2 * BURST_PRIMS_G1);
      tx_busy <= (tst_q != t_off);
      tx_done <= (tst_q == t_neg) && (tcnt_q >= neg_of(tkind_q) - CW'(1));
      ps_done <= (tst_q == t_neg) && (tcnt_q >= neg_of(tkind_q) - CW'(1))
        && (ps_left_q == 3'h0) && (ps_pick_q == 4'h0) && (tkind_q == oob_pkg::sig_init);
    end
  end

  // =====================================================================
  // Receive retiming onto mclk.
  logic [1:0] env_sync_q;
  logic [1:0] pat0_sync_q;
  logic [1:0] pat1_sync_q;
  logic env_prev_q;
  logic burst_ok;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      env_sync_q <= 2'h0;
      pat0_sync_q <= 2'h0;
      pat1_sync_q <= 2'h0;
      env_prev_q <= 1'h0;
    end
    else
    begin
      env_sync_q <= {env_sync_q[0], rx_envelope};
      pat0_sync_q <= {pat0_sync_q[0], rx_pattern[0]};
      pat1_sync_q <= {pat1_sync_q[0], rx_pattern[1]};
      env_prev_q <= burst_ok;
    end
  end

  // The envelope is rate blind; content gates every burst: ALIGN always, D24.3 only with sata_attach.
  assign burst_ok = env_sync_q[1] && ({pat1_sync_q[1], pat0_sync_q[1]} == 2'h1 ||
    ({pat1_sync_q[1], pat0_sync_q[1]} == 2'h2 && sata_attach));

  // =====================================================================
  // Gap measurement and classification.
  logic [CW-1:0] idle_q;
  oob_pkg::oob_sig_t last_q;
  oob_pkg::oob_sig_t held_q;
  logic [2:0] pairs_q;
  oob_pkg::oob_sig_t gap_kind;
  logic burst_start;
  function automatic oob_pkg::oob_sig_t classify(logic [CW-1:0] n);
    if (n >= CW'(WAKE_IDLE_CYC / 2) && n < CW'((WAKE_IDLE_CYC + INIT_IDLE_CYC) / 2))
      classify = oob_pkg::sig_wake;
    else if (n >= CW'((WAKE_IDLE_CYC + INIT_IDLE_CYC) / 2) &&
      n < CW'((INIT_IDLE_CYC + SAS_IDLE_CYC) / 2))
      classify = oob_pkg::sig_init;
    else if (n >= CW'((INIT_IDLE_CYC + SAS_IDLE_CYC) / 2) && n < CW'(SAS_IDLE_CYC * 3 / 2))
      classify = oob_pkg::sig_sas;
    else
      classify = oob_pkg::sig_none;
  endfunction
  assign burst_start = burst_ok && !env_prev_q;
  assign gap_kind = classify(idle_q);
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      idle_q <= '0;
    else if (burst_ok)
      idle_q <= '0;
    else if (idle_q != {CW{1'h1}})
      idle_q <= idle_q + CW'(1);
  end

  // Pair counting saturates at four; longer trains raise nothing.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pairs_q <= 3'h0;
      last_q <= oob_pkg::sig_none;
    end
    else if (burst_start)
    begin
      last_q <= gap_kind;
      if (gap_kind == oob_pkg::sig_none)
        pairs_q <= 3'h0;
      else if (gap_kind != last_q)
        pairs_q <= 3'h1;
      else if (pairs_q != 3'(`OOB_DETECT_PAIRS))
        pairs_q <= pairs_q + 3'h1;
    end
  end

  // Suppression: the held kind is dropped after its negation gap.
  logic det_fire;
  assign det_fire = burst_start && gap_kind != oob_pkg::sig_none && gap_kind == last_q &&
    pairs_q == 3'(`OOB_DETECT_PAIRS - 1) && gap_kind != held_q;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      held_q <= oob_pkg::sig_none;
    else if (det_fire)
      held_q <= gap_kind;
    else if (!burst_ok && held_q != oob_pkg::sig_none && idle_q >= neg_of(held_q))
      held_q <= oob_pkg::sig_none;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rx_detect <= '0;
    else
    begin
      rx_detect.init <= det_fire && gap_kind == oob_pkg::sig_init;
      rx_detect.wake <= det_fire && gap_kind == oob_pkg::sig_wake;
      rx_detect.sas <= det_fire && gap_kind == oob_pkg::sig_sas;
    end
  end

endmodule // oob_phy

// file: rtl/oob_pkg.sv
package oob_pkg;

  // Signal kinds; the initialisation and the reset signal share one code.
  typedef enum logic [1:0] {
    sig_none,
    sig_init,
    sig_wake,
    sig_sas
  } oob_sig_t;

  // Received burst content after decoding.
  typedef enum logic [1:0] {
    pat_none,
    pat_align,
    pat_d243
  } oob_pat_t;

  // Detection report from the receive side.
  typedef struct packed {
    logic init;
    logic wake;
    logic sas;
  } oob_det_t;

endpackage

// file: test/oob_line_model.sv
`timescale 1ns/100ps

module oob_line_model (
  // Clock.
  input wire logic mclk,
  // Commands from the bench.
  input wire logic go,
  input wire logic [7:0] gap,
  input wire logic [7:0] pairs,
  input wire oob_pkg::oob_pat_t pat,
  // Line towards the phy.
  output logic rx_envelope,
  output oob_pkg::oob_pat_t rx_pattern,
  output logic busy
);
  // =====================================================================
  // Remote sender: idle gaps then four-cycle bursts; a silent line decodes as none.
  initial
  begin
    rx_envelope = 1'b0;
    rx_pattern = oob_pkg::pat_none;
    busy = 1'b0;
    forever
    begin
      @(posedge mclk iff go);
      busy = 1'b1;
      repeat (pairs)
      begin
        repeat (gap) @(posedge mclk);
        #1;
        rx_envelope = 1'b1;
        rx_pattern = pat;
        repeat (4) @(posedge mclk);
        #1;
        rx_envelope = 1'b0;
        rx_pattern = oob_pkg::pat_none;
      end
      busy = 1'b0;
    end
  end
endmodule // oob_line_model

// file: test/oob_phy_asserts.sv
`timescale 1ns/100ps

module oob_phy_asserts #(
  parameter int BURST_CYC = 4,
  parameter int INIT_IDLE_CYC = 8,
  parameter int WAKE_IDLE_CYC = 4,
  parameter int SAS_IDLE_CYC = 16,
  parameter int INIT_NEG_CYC = 12,
  parameter int WAKE_NEG_CYC = 6,
  parameter int SAS_NEG_CYC = 24
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic nrst,
  // Block inputs.
  input wire logic tx_req,
  input wire oob_pkg::oob_sig_t tx_kind,
  input wire logic ps_req,
  input wire logic gen1_capable,
  input wire logic [1:0] lowest_rate,
  input wire logic rx_envelope,
  // Block outputs.
  input wire logic tx_burst,
  input wire logic tx_send_align,
  input wire logic [1:0] tx_rate,
  input wire logic [7:0] tx_burst_prims,
  input wire logic tx_busy,
  input wire logic tx_done,
  input wire logic ps_done,
  input wire oob_pkg::oob_det_t rx_detect
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // =====================================================================
  // Burst length, idle gap, burst count and kind of the running signal.
  oob_pkg::oob_sig_t kind_q;
  logic [7:0] blen_q;
  logic [7:0] gap_q;
  logic [3:0] nb_q;
  int idle_c;
  int neg_c;

  assign idle_c = kind_q == oob_pkg::sig_wake ? WAKE_IDLE_CYC :
                  kind_q == oob_pkg::sig_sas ? SAS_IDLE_CYC : INIT_IDLE_CYC;
  assign neg_c = kind_q == oob_pkg::sig_wake ? WAKE_NEG_CYC :
                 kind_q == oob_pkg::sig_sas ? SAS_NEG_CYC : INIT_NEG_CYC;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      blen_q <= 8'h00;
      gap_q <= 8'h00;
      nb_q <= 4'h0;
      kind_q <= oob_pkg::sig_none;
    end
    else
    begin
      blen_q <= tx_burst ? blen_q + 8'h01 : 8'h00;
      gap_q <= tx_burst ? 8'h00 : gap_q + 8'h01;
      if (tx_done)
        nb_q <= 4'h0;
      else if ($rose(tx_burst))
        nb_q <= nb_q + 4'h1;
      if (!tx_busy && ps_req)
        kind_q <= oob_pkg::sig_init;
      else if (!tx_busy && tx_req)
        kind_q <= tx_kind;
    end
  end

  // =====================================================================
  // Assertions.
  align_fill_a: assert property (tx_send_align == tx_burst)
    else $error("align fill differs from burst");
  burst_len_a: assert property ($fell(tx_burst) |-> blen_q == BURST_CYC)
    else $error("burst length wrong");
  idle_gap_a: assert property ($rose(tx_burst) && nb_q != 4'h0 |-> gap_q == idle_c)
    else $error("idle gap wrong");
  six_bursts_a: assert property (tx_done |-> nb_q == 4'h6 && tx_busy)
    else $error("burst count at done wrong");
  negation_a: assert property (tx_done |-> gap_q == neg_c - 1 && !tx_burst)
    else $error("negation time wrong");
  wake_start_a: assert property (!tx_busy && tx_req && !ps_req &&
    tx_kind == oob_pkg::sig_wake |-> !tx_burst [*6] ##1 tx_burst)
    else $error("first burst late or early");
  rate_pick_a: assert property (tx_busy |-> tx_rate == (gen1_capable ? 2'h0 : lowest_rate))
    else $error("burst rate wrong");
  prims_a: assert property (tx_busy |-> tx_burst_prims == (tx_rate == 2'h0 ? 8'h10 : 8'h20))
    else $error("primitive count wrong");
  det_pulse_a: assert property (rx_detect != 3'h0 |-> $onehot(rx_detect) ##1 rx_detect == 3'h0)
    else $error("detect not a single pulse");
  det_time_a: assert property (rx_detect != 3'h0 |-> $past(rx_envelope, 3) && !$past(rx_envelope, 4))
    else $error("detect timing wrong");
  ps_last_a: assert property (ps_done |-> tx_done)
    else $error("selection done without signal done");
endmodule // oob_phy_asserts

bind oob_phy oob_phy_asserts #(
  .BURST_CYC(BURST_CYC),
  .INIT_IDLE_CYC(INIT_IDLE_CYC),
  .WAKE_IDLE_CYC(WAKE_IDLE_CYC),
  .SAS_IDLE_CYC(SAS_IDLE_CYC),
  .INIT_NEG_CYC(INIT_NEG_CYC),
  .WAKE_NEG_CYC(WAKE_NEG_CYC),
  .SAS_NEG_CYC(SAS_NEG_CYC)
) u_asserts (
  .mclk(mclk),
  .nrst(nrst),
  .tx_req(tx_req),
  .tx_kind(tx_kind),
  .ps_req(ps_req),
  .gen1_capable(gen1_capable),
  .lowest_rate(lowest_rate),
  .rx_envelope(rx_envelope),
  .tx_burst(tx_burst),
  .tx_send_align(tx_send_align),
  .tx_rate(tx_rate),
  .tx_burst_prims(tx_burst_prims),
  .tx_busy(tx_busy),
  .tx_done(tx_done),
  .ps_done(ps_done),
  .rx_detect(rx_detect)
);

// file: test/oob_phy_tb.sv
`timescale 1ns/100ps
`include "oob_cfg.svh"

module oob_phy_tb;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic tx_req = 1'b0;
  oob_pkg::oob_sig_t tx_kind = oob_pkg::sig_none;
  logic ps_req = 1'b0;
  logic [3:0] ps_pick_b = 4'h0;
  logic gen1_capable = 1'b1;
  logic [1:0] lowest_rate = 2'h0;
  logic sata_attach = 1'b0;
  logic go = 1'b0;
  logic [7:0] gap = 8'h00;
  logic [7:0] pairs = 8'h00;
  oob_pkg::oob_pat_t pat = oob_pkg::pat_align;
  logic rx_envelope;
  oob_pkg::oob_pat_t rx_pattern;
  logic m_busy;
  logic tx_burst;
  logic tx_send_align;
  logic [1:0] tx_rate;
  logic [7:0] tx_burst_prims;
  logic tx_busy;
  logic tx_done;
  logic ps_done;
  oob_pkg::oob_det_t rx_detect;
  int n_fail = 0;
  int n_tests = 0;
  int c_init = 0;
  int c_wake = 0;
  int c_sas = 0;

  always #4 mclk = ~mclk;

  always @(posedge mclk)
  begin
    c_init += (rx_detect.init === 1'b1);
    c_wake += (rx_detect.wake === 1'b1);
    c_sas += (rx_detect.sas === 1'b1);
  end

  oob_phy #(.BURST_CYC(4), .INIT_IDLE_CYC(8), .WAKE_IDLE_CYC(4), .SAS_IDLE_CYC(16)
  ) u_dut (.mclk(mclk), .nrst(nrst), .tx_req(tx_req), .tx_kind(tx_kind), .ps_req(ps_req),
    .ps_pick_b(ps_pick_b), .gen1_capable(gen1_capable), .lowest_rate(lowest_rate),
    .sata_attach(sata_attach), .rx_envelope(rx_envelope), .rx_pattern(rx_pattern),
    .tx_burst(tx_burst), .tx_send_align(tx_send_align), .tx_rate(tx_rate),
    .tx_burst_prims(tx_burst_prims), .tx_busy(tx_busy), .tx_done(tx_done),
    .ps_done(ps_done), .rx_detect(rx_detect));

  oob_line_model u_line (.mclk(mclk), .go(go), .gap(gap), .pairs(pairs), .pat(pat),
    .rx_envelope(rx_envelope), .rx_pattern(rx_pattern), .busy(m_busy));

  // =====================================================================
  // Shared helpers.
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  task automatic bound(input int k, input int lim);
    if (k >= lim)
    begin
      check("wait bound", 0, k);
      finish_test();
    end
  endtask

  // =====================================================================
  // One signal sent, with a refused request in mid-signal.
  task automatic t_send(input oob_pkg::oob_sig_t kind, input logic cap, input logic [1:0] low,
                        input int exp_t);
    int k;
    int hi;
    int rises;
    logic prev;
    gen1_capable = cap;
    lowest_rate = low;
    tick();
    tick();
    tx_kind = kind;
    tx_req = 1'b1;
    tick();
    tx_req = 1'b0;
    k = 0;
    hi = 0;
    rises = 0;
    prev = 1'b0;
    while (tx_done !== 1'b1 && k < 1000)
    begin
      hi += (tx_burst === 1'b1);
      rises += (tx_burst === 1'b1 && !prev);
      prev = (tx_burst === 1'b1);
      tx_req = (k == 20);
      tick();
      k++;
    end
    bound(k, 1000);
    check("done time", exp_t, k);
    check("bursts", 6, rises);
    check("burst cycles", 24, hi);
    check("rate", cap ? 2'h0 : low, tx_rate);
    check("prims", (cap || low == 2'h0) ? 8'h10 : 8'h20, tx_burst_prims);
    k = 0;
    while (tx_busy !== 1'b0 && k < 10)
    begin
      tick();
      k++;
    end
    bound(k, 10);
    $display("t_send kind %0d done", kind);
  endtask

  // =====================================================================
  // Port selection: five signals, gap b after the second, priority over a plain request.
  task automatic t_ps();
    int k;
    int np;
    int nd;
    int t[$];
    logic prev;
    int pa = `OOB_CYC(`OOB_PS_A_NS);
    int pb = `OOB_CYC(`OOB_PS_B_NS);
    ps_pick_b = 4'h2;
    tx_kind = oob_pkg::sig_wake;
    ps_req = 1'b1;
    tx_req = 1'b1;
    tick();
    ps_req = 1'b0;
    tx_req = 1'b0;
    k = 0;
    np = 0;
    nd = 0;
    prev = 1'b0;
    while (nd < 5 && k < 15000)
    begin
      if (tx_burst === 1'b1 && !prev)
        t.push_back(k);
      prev = (tx_burst === 1'b1);
      nd += (tx_done === 1'b1);
      np += (ps_done === 1'b1);
      tick();
      k++;
    end
    bound(k, 15000);
    check("ps bursts", 30, t.size());
    check("ps done", 1, np);
    if (t.size() == 30)
    begin
      check("gap b minus a", pb - pa, (t[12] - t[6]) - (t[6] - t[0]));
      check("gap a repeat", t[6] - t[0], t[18] - t[12]);
      check("gap a range", 1, (t[6] - t[0]) >= pa && (t[6] - t[0]) <= pa + 9);
    end
    tick();
    tick();
    $display("t_ps done");
  endtask

  // =====================================================================
  // Far side sends n pairs; detection counts are compared.
  task automatic t_rx(input logic [7:0] g, input logic [7:0] n, input oob_pkg::oob_pat_t p,
                      input logic att, input int ei, input int ew, input int es);
    int k;
    sata_attach = att;
    gap = g;
    pairs = n;
    pat = p;
    c_init = 0;
    c_wake = 0;
    c_sas = 0;
    go = 1'b1;
    tick();
    go = 1'b0;
    k = 0;
    while (m_busy !== 1'b0 && k < 1000)
    begin
      tick();
      k++;
    end
    bound(k, 1000);
    repeat (40) tick();
    check("init detects", ei, c_init);
    check("wake detects", ew, c_wake);
    check("sas detects", es, c_sas);
    $display("t_rx gap %0d pairs %0d done", g, n);
  endtask

  initial
  begin
    repeat (20) @(posedge mclk);
    #1;
    nrst = 1'b1;
    repeat (5) tick();
    t_send(oob_pkg::sig_init, 1'b1, 2'h0, 72 + `OOB_CYC(`OOB_INIT_NEG_NS));
    t_send(oob_pkg::sig_wake, 1'b0, 2'h1, 48 + `OOB_CYC(`OOB_WAKE_NEG_NS));
    t_send(oob_pkg::sig_sas, 1'b0, 2'h2, 120 + `OOB_CYC(`OOB_SAS_NEG_NS));
    t_ps();
    t_rx(8'h08, 8'h05, oob_pkg::pat_align, 1'b0, 1, 0, 0);
    t_rx(8'h04, 8'h08, oob_pkg::pat_align, 1'b0, 0, 1, 0);
    t_rx(8'h10, 8'h05, oob_pkg::pat_align, 1'b0, 0, 0, 1);
    t_rx(8'h08, 8'h03, oob_pkg::pat_align, 1'b0, 0, 0, 0);
    t_rx(8'h08, 8'h05, oob_pkg::pat_d243, 1'b0, 0, 0, 0);
    t_rx(8'h08, 8'h05, oob_pkg::pat_d243, 1'b1, 1, 0, 0);
    finish_test();
  end
endmodule // oob_phy_tb
